// [hdl/rso_pkg.sv]
/*
  package of the relay status output selector: register offsets, reset
  values, field widths and the relay function codes.
  assumes a 32-bit apb register bus and a single 100 MHz clock.
*/
`default_nettype none

package rso_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int FUNC_W = 4;
  localparam int N_CH = 3;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_UPPER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LOWER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_R1_LOW = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h18;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [FUNC_W-1:0] FUNC_RST = 4'h0;
  localparam logic [VAL_W-1:0] UPPER_RST = 16'hffff;
  localparam logic [VAL_W-1:0] LOWER_RST = 16'h0000;
  localparam logic [VAL_W-1:0] R1_LOW_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IMASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // interrupt bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_CLOSE = 0;
  localparam int IRQ_OPEN = 1;

  // ----------------------------------------------------------------
  // channel positions of the threshold comparators
  // ----------------------------------------------------------------
  localparam int CH_CUR = 0;
  localparam int CH_TRQ = 1;
  localparam int CH_AIN2 = 2;

  // ----------------------------------------------------------------
  // relay function codes
  // ----------------------------------------------------------------
  typedef enum logic [FUNC_W-1:0] {
    RSO_FN_RUNNING = 4'h0,
    RSO_FN_HEALTHY = 4'h1,
    RSO_FN_AT_SPEED = 4'h2,
    RSO_FN_SPEED_NZ = 4'h3,
    RSO_FN_CURRENT = 4'h5,
    RSO_FN_TORQUE = 4'h6,
    RSO_FN_AIN2 = 4'h7,
    RSO_FN_FIRE = 4'h9,
    RSO_FN_MAINT = 4'ha,
    RSO_FN_READY = 4'hb,
    RSO_FN_TRIPPED = 4'hc
  } rso_func_t;

endpackage

`default_nettype wire

// [hdl/rso_hyst.sv]
/*
  one threshold comparator with hysteresis: output rises when the value
  goes above the upper limit and falls only once it drops below the
  lower limit.
  assumes value and limits are synchronous to clk_sys.
*/
`default_nettype none

module rso_hyst import rso_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // value and limits
  input wire logic [VAL_W-1:0] value,
  input wire logic [VAL_W-1:0] upper,
  input wire logic [VAL_W-1:0] lower,
  // result
  output logic above_ff
);

  // ----------------------------------------------------------------
  // hysteresis state
  // ----------------------------------------------------------------
  // rising wins when limits overlap, so a bad setting fails closed
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      above_ff <= 1'b0;
    end else if (value > upper) begin // [RULE3] [RULE4]
      above_ff <= 1'b1;
    end else if (value < lower) begin // [RULE3] [RULE4]
      above_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_hyst_rise: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE3]
    (value > upper) |=> above_ff)
    else $error("hysteresis output did not rise above upper limit");

  chk_hyst_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE4]
    (above_ff && value >= lower) |=> above_ff)
    else $error("hysteresis output fell before lower limit");

  chk_hyst_fall: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE3]
    (value < lower && !(value > upper)) |=> !above_ff)
    else $error("hysteresis output did not fall below lower limit");

endmodule // rso_hyst

`default_nettype wire

// [hdl/rso_top.sv]
/*
  relay status output selector: apb registers, function code select,
  three hysteresis comparators, relay drive and edge interrupts.
  assumes all status inputs are synchronous to clk_sys and that the
  relay driver closes the contacts while relay2_closed is high.
*/
// Local design decisions: the register addresses and the APB interface to the registers.
`default_nettype none

// Overview of operation
// RULE1 - software picks a function code deciding what energises relay two
// RULE2 - relay output high closes the contacts, low opens them
// RULE3 - threshold codes rise above upper limit, fall only below lower
// RULE4 - upper and lower limits are separate settable registers
// RULE5 - code 0: relay high while the motor output stage is enabled
// RULE6 - code 1: relay high when powered and no fault exists
// RULE7 - code 2: relay high when output frequency equals set-point
// RULE8 - code 3: relay high when output frequency is above zero
// RULE9 - code 5: relay follows the motor current threshold comparator
// RULE10 - code 6: relay follows the motor torque threshold comparator
// RULE11 - code 7: relay follows the second analog input comparator
// RULE12 - code 9: relay high while emergency override mode runs
// RULE13 - code 10: relay high once the service timer has expired
// RULE14 - code 11: relay high in auto, no trip, safety circuit on
// RULE15 - code 12: relay high while the drive is tripped
// RULE16 - a shared lower-limit register feeds the first relay and output
// RULE17 - undefined codes such as 4, 8 and 14 hold the relay open
module rso_top import rso_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive status sources
  input wire logic motor_enabled,
  input wire logic drive_powered,
  input wire logic fault_present,
  input wire logic [VAL_W-1:0] out_freq,
  input wire logic [VAL_W-1:0] setpoint_freq,
  input wire logic [VAL_W-1:0] motor_current,
  input wire logic [VAL_W-1:0] motor_torque,
  input wire logic [VAL_W-1:0] analog_in2,
  input wire logic fire_mode_active,
  input wire logic service_expired,
  input wire logic auto_mode,
  input wire logic trip_present,
  input wire logic safety_enabled,
  // relay and shared limit
  output logic relay2_closed,
  output logic [VAL_W-1:0] relay1_lower_limit,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [FUNC_W-1:0] func_ff;
  logic [VAL_W-1:0] upper_ff;
  logic [VAL_W-1:0] lower_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic [N_CH-1:0] above;
  logic [VAL_W-1:0] chan_val [N_CH];
  logic nxt_relay;
  logic acc_cyc;
  logic wr_fire;
  logic addr_hit;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // one wait state: read data are registered while pready is still low, write data are captured while pready is high
  assign acc_cyc = psel & penable;
  assign wr_fire = acc_cyc & pready & pwrite;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= acc_cyc & ~pready;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr)
      OFS_FUNC: rd_mux[FUNC_W-1:0] = func_ff;
      OFS_UPPER: rd_mux[VAL_W-1:0] = upper_ff;
      OFS_LOWER: rd_mux[VAL_W-1:0] = lower_ff;
      OFS_R1_LOW: rd_mux[VAL_W-1:0] = relay1_lower_limit;
      OFS_STATUS: rd_mux[N_CH:0] = {above, relay2_closed};
      OFS_ISTAT: rd_mux[IRQ_W-1:0] = irq_stat_ff;
      OFS_IMASK: rd_mux[IRQ_W-1:0] = irq_mask_ff;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (acc_cyc & ~pready) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~addr_hit;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      func_ff <= FUNC_RST;
    end else if (wr_fire && paddr == OFS_FUNC) begin
      func_ff <= pwdata[FUNC_W-1:0]; // [RULE1]
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      upper_ff <= UPPER_RST;
      lower_ff <= LOWER_RST;
    end else if (wr_fire && paddr == OFS_UPPER) begin
      upper_ff <= pwdata[VAL_W-1:0]; // [RULE4]
    end else if (wr_fire && paddr == OFS_LOWER) begin
      lower_ff <= pwdata[VAL_W-1:0]; // [RULE4]
    end
  end

  // only stored and exported; the first relay lives elsewhere
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      relay1_lower_limit <= R1_LOW_RST;
    end else if (wr_fire && paddr == OFS_R1_LOW) begin
      relay1_lower_limit <= pwdata[VAL_W-1:0]; // [RULE16]
    end
  end

  // ----------------------------------------------------------------
  // threshold comparators
  // ----------------------------------------------------------------
  assign chan_val[CH_CUR] = motor_current;
  assign chan_val[CH_TRQ] = motor_torque;
  assign chan_val[CH_AIN2] = analog_in2;

  // all three share one limit pair, so each tracks even when unselected
  genvar gi;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_hyst
      rso_hyst u_hyst ( // [RULE3]
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .value(chan_val[gi]),
        .upper(upper_ff),
        .lower(lower_ff),
        .above_ff(above[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // function select
  // ----------------------------------------------------------------
  always_comb begin
    nxt_relay = 1'b0;
    unique case (func_ff)
      RSO_FN_RUNNING: nxt_relay = motor_enabled; // [RULE5]
      RSO_FN_HEALTHY: nxt_relay = drive_powered & ~fault_present; // [RULE6]
      RSO_FN_AT_SPEED: nxt_relay = (out_freq == setpoint_freq); // [RULE7]
      RSO_FN_SPEED_NZ: nxt_relay = (out_freq != '0); // [RULE8]
      RSO_FN_CURRENT: nxt_relay = above[CH_CUR]; // [RULE9]
      RSO_FN_TORQUE: nxt_relay = above[CH_TRQ]; // [RULE10]
      RSO_FN_AIN2: nxt_relay = above[CH_AIN2]; // [RULE11]
      RSO_FN_FIRE: nxt_relay = fire_mode_active; // [RULE12]
      RSO_FN_MAINT: nxt_relay = service_expired; // [RULE13]
      RSO_FN_READY: begin
        nxt_relay = auto_mode & ~trip_present & safety_enabled; // [RULE14]
      end
      RSO_FN_TRIPPED: nxt_relay = trip_present; // [RULE15]
      default: nxt_relay = 1'b0; // [RULE17]
    endcase
  end

  // registered so the relay driver never sees select glitches
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      relay2_closed <= 1'b0;
    end else begin
      relay2_closed <= nxt_relay; // [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_evt[IRQ_CLOSE] = nxt_relay & ~relay2_closed;
  assign irq_evt[IRQ_OPEN] = ~nxt_relay & relay2_closed;
  assign irq_clr = (wr_fire && paddr == OFS_ISTAT) ?
                   pwdata[IRQ_W-1:0] : '0;

  // set beats clear so an edge in the clearing cycle is kept
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_ff <= IMASK_RST;
    end else if (wr_fire && paddr == OFS_IMASK) begin
      irq_mask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  chk_func_write: assert property ( // [RULE1]
    (wr_fire && paddr == OFS_FUNC) |=> (func_ff == $past(pwdata[3:0])))
    else $error("function code write not stored");

  chk_code_running: assert property ( // [RULE5]
    (func_ff == RSO_FN_RUNNING) |=> (relay2_closed == $past(motor_enabled)))
    else $error("running code does not follow motor enable");

  chk_code_healthy: assert property ( // [RULE6]
    (func_ff == RSO_FN_HEALTHY && drive_powered && !fault_present)
    |=> relay2_closed)
    else $error("healthy code not closed when powered without fault");

  chk_code_speed: assert property ( // [RULE7]
    (func_ff == RSO_FN_AT_SPEED && out_freq != setpoint_freq)
    |=> !relay2_closed)
    else $error("at-speed code closed off set-point");

  chk_code_nonzero: assert property ( // [RULE8]
    (func_ff == RSO_FN_SPEED_NZ)
    |=> (relay2_closed == ($past(out_freq) != 16'h0000)))
    else $error("speed above zero code wrong");

  chk_code_current: assert property ( // [RULE9]
    (func_ff == RSO_FN_CURRENT) |=> (relay2_closed == $past(above[0])))
    else $error("current code does not follow comparator");

  chk_code_fire: assert property ( // [RULE12]
    (func_ff == RSO_FN_FIRE && fire_mode_active) |=> relay2_closed)
    else $error("fire mode code not closed");

  chk_code_ready: assert property ( // [RULE14]
    (func_ff == RSO_FN_READY && trip_present) |=> !relay2_closed)
    else $error("ready code closed during trip");

  chk_code_trip: assert property ( // [RULE15]
    (func_ff == RSO_FN_TRIPPED)
    |=> (relay2_closed == $past(trip_present)))
    else $error("tripped code does not follow trip");

  chk_code_undef: assert property ( // [RULE17]
    (func_ff == 4'h4 || func_ff == 4'h8 || func_ff == 4'he)
    |=> !relay2_closed)
    else $error("undefined code closed the relay");

  chk_irq_close: assert property (
    ($rose(relay2_closed) && irq_mask_ff[0]) |-> ##[1:2] irq)
    else $error("close interrupt not raised");

  chk_irq_open: assert property (
    ($fell(relay2_closed) && irq_mask_ff[IRQ_OPEN]) |-> ##[1:2] irq)
    else $error("open interrupt not raised");

  chk_code_match: assert property ( // [RULE7]
    (func_ff == RSO_FN_AT_SPEED && out_freq == setpoint_freq)
    |=> relay2_closed)
    else $error("at-speed code open on set-point");

  chk_code_fault: assert property ( // [RULE6]
    (func_ff == RSO_FN_HEALTHY && fault_present) |=> !relay2_closed)
    else $error("healthy code closed during fault");

  chk_code_torque: assert property ( // [RULE10]
    (func_ff == RSO_FN_TORQUE) |=> (relay2_closed == $past(above[CH_TRQ])))
    else $error("torque code does not follow comparator");

  chk_code_ain: assert property ( // [RULE11]
    (func_ff == RSO_FN_AIN2) |=> (relay2_closed == $past(above[CH_AIN2])))
    else $error("second input code does not follow comparator");

  chk_code_maint: assert property ( // [RULE13]
    (func_ff == RSO_FN_MAINT)
    |=> (relay2_closed == $past(service_expired)))
    else $error("maintenance code does not follow service timer");

  chk_upper_write: assert property ( // [RULE4]
    (wr_fire && paddr == OFS_UPPER)
    |=> (upper_ff == $past(pwdata[VAL_W-1:0])))
    else $error("upper limit write not stored");

  chk_lower_write: assert property ( // [RULE4]
    (wr_fire && paddr == OFS_LOWER)
    |=> (lower_ff == $past(pwdata[VAL_W-1:0])))
    else $error("lower limit write not stored");

  chk_r1_write: assert property ( // [RULE16]
    (wr_fire && paddr == OFS_R1_LOW)
    |=> (relay1_lower_limit == $past(pwdata[VAL_W-1:0])))
    else $error("shared lower limit write not stored");

  chk_pready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held for more than one cycle");

  chk_unmapped_err: assert property (
    (acc_cyc && !pready && !addr_hit) |=> (pready && pslverr))
    else $error("unmapped access without error response");

endmodule // rso_top

`default_nettype wire

// [bench/rso_relay_load.sv]
/*
  model of the equipment wired across the second relay's contacts: it
  sees a closed loop while the contacts are joined.
  assumes the relay coil follows relay2_closed with no bounce.
*/
`default_nettype none

module rso_relay_load (
  // relay drive
  input wire logic relay2_closed,
  // loop seen by the equipment
  output logic contacts_joined
);
  timeunit 1ns;
  timeprecision 1ps;
  // no bounce modelled, so contact debounce is not exercised here
  assign contacts_joined = relay2_closed;
endmodule // rso_relay_load

`default_nettype wire

// [bench/rso_top_tb_top.sv]
/*
  bench top of the relay status output selector: apb master, status
  stimulus, a note queue of expected replies and a reply monitor.
  assumes one clk_sys at 100 MHz and the relay load model beside it.
*/
`default_nettype none

module rso_top_tb_top import rso_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    logic err;
    string nm;
  } rso_note_t;
  localparam logic [15:0] UP = 16'h8000;
  localparam logic [15:0] LO = 16'h4000;
  rso_note_t notes[$];
  rso_note_t n;
  int num_errors = 0;
  int checked = 0;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] bits = 8'h00;
  logic [15:0] ofr = 16'h0;
  logic [15:0] spf = 16'h0;
  logic [15:0] cur = 16'h0;
  logic [15:0] trq = 16'h0;
  logic [15:0] ain = 16'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic relay2_closed;
  logic [15:0] relay1_lower_limit;
  logic irq;
  logic contacts_joined;
  logic [2:0] ab = 3'h0;
  logic [31:0] s = 32'hff69;

  rso_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_enabled(bits[0]), .drive_powered(bits[1]),
    .fault_present(bits[2]), .out_freq(ofr), .setpoint_freq(spf),
    .motor_current(cur), .motor_torque(trq), .analog_in2(ain),
    .fire_mode_active(bits[3]), .service_expired(bits[4]),
    .auto_mode(bits[5]), .trip_present(bits[6]),
    .safety_enabled(bits[7]), .relay2_closed(relay2_closed),
    .relay1_lower_limit(relay1_lower_limit), .irq(irq));
  rso_relay_load u_load (.relay2_closed(relay2_closed),
    .contacts_joined(contacts_joined));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [15:0] pick(input logic [2:0] x);
    case (x)
      3'h0: return LO - 16'h1;
      3'h1: return LO;
      3'h2: return 16'h6000;
      3'h3: return UP;
      3'h4: return UP + 16'h1;
      3'h5: return 16'h0000;
      3'h6: return 16'hffff;
      default: return 16'h5555;
    endcase
  endfunction

  function automatic logic rel(input logic [3:0] c);
    case (c)
      4'h0: return bits[0];
      4'h1: return bits[1] & ~bits[2];
      4'h2: return ofr == spf;
      4'h3: return ofr != 16'h0;
      4'h5: return ab[0];
      4'h6: return ab[1];
      4'h7: return ab[2];
      4'h9: return bits[3];
      4'ha: return bits[4];
      4'hb: return bits[5] & ~bits[6] & bits[7];
      4'hc: return bits[6];
      default: return 1'b0;
    endcase
  endfunction

  // strict compares: equal to a limit holds the previous state
  task automatic hyst(input logic [15:0] v, input int ch);
    if (v > UP) ab[ch] = 1'b1;
    else if (v < LO) ab[ch] = 1'b0;
  endtask

  task automatic results();
    $display("counts: checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] v,
      input string nm);
    checked++;
    if (v !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, e, v);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic [31:0] m,
      input logic er, input string nm);
    int i;
    notes.push_back('{e, m, er, nm});
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      num_errors++;
      $display("[FAIL] pready exp 1 seen 0");
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic er);
    apb(1'b1, a, d, 32'h0, 32'h0, er, "write");
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // reply monitor: oldest note against each completed transfer
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        num_errors++;
        $display("[FAIL] reply exp none seen one");
      end else begin
        n = notes.pop_front();
        chk({n.err, n.exp & n.msk}, {pslverr, prdata & n.msk}, n.nm);
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] vc;
    logic [15:0] vt;
    logic [15:0] va;
    logic [3:0] fc;
    wt(4);
    arst_n <= 1'b1;
    apb(0, OFS_FUNC, 0, 32'h0, 32'hf, 0, "func");
    apb(0, OFS_UPPER, 0, 32'hffff, 32'hffff, 0, "upper");
    apb(0, OFS_LOWER, 0, 32'h0, 32'hffff, 0, "lower");
    apb(0, OFS_IMASK, 0, 32'h0, 32'h3, 0, "imask");
    apb(0, OFS_ISTAT, 0, 32'h0, 32'h3, 0, "istat");
    apb(0, 8'h1c, 0, 32'h0, 32'hffffffff, 1, "unmapped");
    wr(8'h20, 32'h1, 1'b1);
    s = lfsr(s);
    wr(OFS_R1_LOW, s, 1'b0);
    apb(0, OFS_R1_LOW, 0, s, 32'hffff, 0, "r1 low");
    chk(s[15:0], relay1_lower_limit, "r1 port");
    wr(OFS_UPPER, UP, 1'b0);
    wr(OFS_LOWER, LO, 1'b0);
    ab = 3'h0;
    $display("test registers done");
    for (int k = 0; k < 80; k++) begin
      s = lfsr(s);
      fc = s[3:0];
      wr(OFS_FUNC, {28'h0, fc}, 1'b0);
      s = lfsr(s);
      vc = pick(s[2:0]);
      vt = pick(s[5:3]);
      va = pick(s[8:6]);
      bits <= s[16:9];
      spf <= s[31:16];
      ofr <= s[17] ? s[31:16] : (s[18] ? 16'h0 : s[31:16] ^ 16'h1);
      cur <= vc;
      trq <= vt;
      ain <= va;
      hyst(vc, CH_CUR);
      hyst(vt, CH_TRQ);
      hyst(va, CH_AIN2);
      wt(3);
      apb(0, OFS_FUNC, 0, {28'h0, fc}, 32'hf, 0, "func");
      apb(0, OFS_STATUS, 0, {ab, rel(fc)}, 32'hf, 0, "status");
      chk(rel(fc), contacts_joined, "contacts");
    end
    $display("test codes done");
    wr(OFS_FUNC, 32'h0, 1'b0);
    bits <= 8'h00;
    wt(3);
    wr(OFS_ISTAT, 32'h3, 1'b0);
    wr(OFS_IMASK, 32'h1, 1'b0);
    bits <= 8'h01;
    wt(3);
    chk(1'b1, irq, "irq close");
    apb(0, OFS_ISTAT, 0, 32'h1, 32'h3, 0, "istat close");
    wr(OFS_ISTAT, 32'h1, 1'b0);
    wt(2);
    chk(1'b0, irq, "irq cleared");
    bits <= 8'h00;
    wt(3);
    chk(1'b0, irq, "irq masked");
    apb(0, OFS_ISTAT, 0, 32'h2, 32'h3, 0, "istat open");
    wr(OFS_IMASK, 32'h3, 1'b0);
    wt(2);
    chk(1'b1, irq, "irq open");
    wr(OFS_ISTAT, 32'h2, 1'b0);
    wt(2);
    chk(1'b0, irq, "irq idle");
    $display("test interrupts done");
    wt(2);
    chk(0, notes.size(), "notes left");
    results();
  end
endmodule // rso_top_tb_top

`default_nettype wire
